// *** logic/ciec_pkg.sv ***
// Package: register map, field positions, reset values and types
package ciec_pkg;
    localparam logic [5:0] CIEC_OFS_COMMAND = 6'h01;
    localparam logic [5:0] CIEC_OFS_PRIMARY = 6'h02;
    localparam logic [5:0] CIEC_OFS_SECONDARY = 6'h03;
    localparam logic [7:0] CIEC_RST_COMMAND = 8'h20;
    localparam logic [7:0] CIEC_RST_PRIMARY = 8'h80;
    localparam logic [7:0] CIEC_RST_SECONDARY = 8'h00;
    localparam int CIEC_BIT_RCV_OFF = 5;
    localparam int CIEC_BIT_SLEEP = 4;
    localparam int CIEC_BIT_INVERT = 7;
    localparam int CIEC_BIT_PUSH_PULL = 7;
    localparam logic [7:0] CIEC_MASK_COMMAND = 8'h3F;
    localparam logic [7:0] CIEC_MASK_PRIMARY = 8'hFF;
    localparam logic [7:0] CIEC_MASK_SECONDARY = 8'h9F;
    localparam logic [4:0] CIEC_MASK_SEC_EN = 5'h1F;
    localparam logic [3:0] CIEC_CMD_IDLE = 4'h0;
    localparam logic [3:0] CIEC_CMD_SOFT_RESTART = 4'hF;
    // Cycles from a sleep-clear write to ready; arbitrary plain default
    localparam logic [7:0] CIEC_WAKE_CYCLES = 8'h10;

    typedef enum logic [1:0] {
        CIEC_AWAKE,
        CIEC_ASLEEP,
        CIEC_WAKING
    } ciec_power_type;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] primary;
        logic [7:0] secondary;
        ciec_power_type power;
        logic [7:0] wake_count;
    } ciec_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } ciec_access_type;

    typedef struct packed {
        logic tx_done_flag;
        logic rx_done_flag;
        logic idle_event_flag;
        logic high_level_flag;
        logic low_level_flag;
        logic fault_event_flag;
        logic timer_expiry_flag;
    } ciec_primary_flags_type;

    typedef struct packed {
        logic side_input_active_flag;
        logic mode_detected_flag;
        logic checksum_done_flag;
        logic field_present_flag;
        logic field_lost_flag;
    } ciec_secondary_flags_type;
endpackage

// *** logic/ciec_control.sv ***
// Command register, interrupt enables and alert pin control
// What this block does
// - Command bit 5 set switches receiver analog off until cleared.
// - Writing 1 to command bit 4 enters soft sleep.
// - Clearing sleep starts wake-up; bit reads 1 until ready.
// - While soft restart runs, a set sleep bit of a command write is ignored.
// - Low four command bits start a command and read running command.
// - Primary bit 7 inverts the alert pin versus summary status.
// - Reset values of polarity and drive leave the pin high impedance.
// - Primary bits 6..0 enable seven primary requests onto the pin.
// - Secondary bits 4..0 enable five secondary requests onto the pin.
// - Secondary bit 7 selects push-pull, else open-drain.
// - Internal machines update the command field; done returns idle.
`timescale 1ns/1ps
module ciec_control (
    input wire logic clk,
    input wire logic srst,
    input wire ciec_pkg::ciec_access_type access,
    output logic [7:0] rdata,
    input wire logic engine_load,
    input wire logic [3:0] engine_command,
    input wire logic engine_done,
    input wire ciec_pkg::ciec_primary_flags_type primary_flags,
    input wire ciec_pkg::ciec_secondary_flags_type secondary_flags,
    output logic receiver_analog_off,
    output logic sleep_active,
    output logic [3:0] active_command,
    output logic summary_irq,
    output logic alert_pin_out,
    output logic alert_pin_oe
);
    ciec_pkg::ciec_state_type state;
    ciec_pkg::ciec_state_type next_state;
    logic [7:0] next_rdata;
    logic prim_hit;
    logic sec_hit;
    logic level;

    function automatic logic [7:0] ciec_read(
        input ciec_pkg::ciec_state_type s,
        input logic [5:0] addr
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            ciec_pkg::CIEC_OFS_COMMAND: begin
                v = s.command & ciec_pkg::CIEC_MASK_COMMAND;
                // Sleep reads 1 until wake-up finishes
                if (s.power != ciec_pkg::CIEC_AWAKE) begin
                    v[ciec_pkg::CIEC_BIT_SLEEP] = 1'b1;
                end
            end
            ciec_pkg::CIEC_OFS_PRIMARY: v = s.primary;
            ciec_pkg::CIEC_OFS_SECONDARY: begin
                v = s.secondary & ciec_pkg::CIEC_MASK_SECONDARY;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        next_state = state;
        if (access.wr && access.addr == ciec_pkg::CIEC_OFS_COMMAND) begin
            next_state.command[5:0] = access.wdata[5:0];
            next_state.command[7:6] = 2'b00;
            if (access.wdata[ciec_pkg::CIEC_BIT_SLEEP]) begin
                // Restart blocks sleep: avoids losing the restart midway
                if (state.command[3:0] ==
                        ciec_pkg::CIEC_CMD_SOFT_RESTART) begin
                    next_state.command[ciec_pkg::CIEC_BIT_SLEEP] =
                        1'b0;
                end else begin
                    next_state.power = ciec_pkg::CIEC_ASLEEP;
                end
            end else if (state.power == ciec_pkg::CIEC_ASLEEP) begin
                next_state.power = ciec_pkg::CIEC_WAKING;
                next_state.wake_count = ciec_pkg::CIEC_WAKE_CYCLES;
            end
        end else begin
            // Host write wins over an engine update in the same cycle
            if (engine_load) begin
                next_state.command[3:0] = engine_command;
            end else if (engine_done) begin
                next_state.command[3:0] = ciec_pkg::CIEC_CMD_IDLE;
            end
        end
        if (access.wr && access.addr == ciec_pkg::CIEC_OFS_PRIMARY) begin
            next_state.primary = access.wdata & ciec_pkg::CIEC_MASK_PRIMARY;
        end
        if (access.wr && access.addr == ciec_pkg::CIEC_OFS_SECONDARY) begin
            next_state.secondary =
                access.wdata & ciec_pkg::CIEC_MASK_SECONDARY;
        end
        if (state.power == ciec_pkg::CIEC_WAKING && !(access.wr &&
                access.addr == ciec_pkg::CIEC_OFS_COMMAND)) begin
            if (state.wake_count == 8'h01) begin
                next_state.power = ciec_pkg::CIEC_AWAKE;
                next_state.command[ciec_pkg::CIEC_BIT_SLEEP] = 1'b0;
                next_state.wake_count = 8'h00;
            end else begin
                next_state.wake_count = state.wake_count - 8'h01;
            end
        end
        case (next_state.power)
            ciec_pkg::CIEC_AWAKE: next_state.command[4] = 1'b0;
            ciec_pkg::CIEC_ASLEEP: next_state.command[4] = 1'b1;
            ciec_pkg::CIEC_WAKING: next_state.command[4] = 1'b1;
            default: next_state.power = ciec_pkg::CIEC_AWAKE;
        endcase
        if (srst) begin
            next_state.command = ciec_pkg::CIEC_RST_COMMAND;
            next_state.primary = ciec_pkg::CIEC_RST_PRIMARY;
            next_state.secondary = ciec_pkg::CIEC_RST_SECONDARY;
            next_state.power = ciec_pkg::CIEC_AWAKE;
            next_state.wake_count = 8'h00;
        end
        next_rdata = srst ? 8'h00 :
            (access.rd ? ciec_read(state, access.addr) : rdata);
    end

    always_ff @(posedge clk) begin
        state <= next_state;
        rdata <= next_rdata;
    end

    always_comb begin
        prim_hit = |(primary_flags & state.primary[6:0]);
        sec_hit = |(secondary_flags &
            state.secondary[4:0] & ciec_pkg::CIEC_MASK_SEC_EN);
        summary_irq = prim_hit | sec_hit;
        level = summary_irq ^
            state.primary[ciec_pkg::CIEC_BIT_INVERT];
        alert_pin_out = level;
        // Open drain only pulls low; with reset values the pin floats
        alert_pin_oe = state.secondary[ciec_pkg::CIEC_BIT_PUSH_PULL] |
            ~level;
        receiver_analog_off =
            state.command[ciec_pkg::CIEC_BIT_RCV_OFF];
        sleep_active = state.power != ciec_pkg::CIEC_AWAKE;
        active_command = state.command[3:0];
    end

    polarity_pin_a: assert property (@(posedge clk) disable iff (srst)
        alert_pin_out == (summary_irq ^ state.primary[7]))
        else $error("alert pin polarity wrong");
    reset_float_a: assert property (@(posedge clk)
        $past(srst) && !srst && !summary_irq |-> !alert_pin_oe)
        else $error("alert pin driven after reset");
    push_pull_a: assert property (@(posedge clk) disable iff (srst)
        state.secondary[7] |-> alert_pin_oe)
        else $error("push-pull pin not driven");
    open_drain_a: assert property (@(posedge clk) disable iff (srst)
        !state.secondary[7] && alert_pin_out |-> !alert_pin_oe)
        else $error("open drain drove high");
    summary_or_a: assert property (@(posedge clk) disable iff (srst)
        summary_irq == (|(primary_flags & state.primary[6:0]) |
            |(secondary_flags & state.secondary[4:0])))
        else $error("summary mismatch");
    rcv_off_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 |=>
        receiver_analog_off == $past(access.wdata[5]))
        else $error("receiver off not written");
    sleep_enter_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 && access.wdata[4] &&
        state.command[3:0] != 4'hF |=> sleep_active)
        else $error("sleep not entered");
    wake_hold_a: assert property (@(posedge clk) disable iff (srst)
        $rose(state.power == ciec_pkg::CIEC_WAKING) |->
        (sleep_active && state.command[4]) [*8])
        else $error("sleep bit dropped early");
    restart_block_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 && state.command[3:0] == 4'hF &&
        !sleep_active |=> !sleep_active)
        else $error("sleep set during restart");
    cmd_done_a: assert property (@(posedge clk) disable iff (srst)
        engine_done && !engine_load && !access.wr |=>
        active_command == 4'h0)
        else $error("command not back to idle");
    reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
        state.command[7:6] == 2'b00 && state.secondary[6:5] == 2'b00)
        else $error("reserved bits set");
    cmd_start_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 |=>
        active_command == $past(access.wdata[3:0]))
        else $error("command not started");

    // Reset values, checked on the first edge after release
    rst_command_a: assert property (@(posedge clk)
        $past(srst) && !srst |->
        state.command == ciec_pkg::CIEC_RST_COMMAND)
        else $error("command reset value wrong");
    rst_primary_a: assert property (@(posedge clk)
        $past(srst) && !srst |->
        state.primary == ciec_pkg::CIEC_RST_PRIMARY)
        else $error("primary reset value wrong");
    rst_secondary_a: assert property (@(posedge clk)
        $past(srst) && !srst |->
        state.secondary == ciec_pkg::CIEC_RST_SECONDARY)
        else $error("secondary reset value wrong");
    rst_awake_a: assert property (@(posedge clk)
        $past(srst) && !srst |-> !sleep_active)
        else $error("asleep after reset");

    // Register contents move only on their own writes
    rcv_hold_a: assert property (@(posedge clk) disable iff (srst)
        !(access.wr && access.addr == 6'h01) |=>
        $stable(receiver_analog_off))
        else $error("receiver off changed without write");
    prim_write_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h02 |=>
        state.primary == $past(access.wdata))
        else $error("primary enable not written");
    sec_write_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h03 |=>
        state.secondary == ($past(access.wdata) & 8'h9F))
        else $error("secondary enable not written");
    prim_hold_a: assert property (@(posedge clk) disable iff (srst)
        !(access.wr && access.addr == 6'h02) |=> $stable(state.primary))
        else $error("primary enable changed alone");
    sec_hold_a: assert property (@(posedge clk) disable iff (srst)
        !(access.wr && access.addr == 6'h03) |=> $stable(state.secondary))
        else $error("secondary enable changed alone");

    // Sleep and wake-up sequence
    wake_start_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 && !access.wdata[4] &&
        state.power == ciec_pkg::CIEC_ASLEEP |=>
        state.power == ciec_pkg::CIEC_WAKING &&
        state.wake_count == ciec_pkg::CIEC_WAKE_CYCLES)
        else $error("wake-up not started");
    wake_done_a: assert property (@(posedge clk) disable iff (srst)
        state.power == ciec_pkg::CIEC_WAKING && state.wake_count == 8'h01 &&
        !(access.wr && access.addr == 6'h01) |=> !sleep_active)
        else $error("wake-up not finished");
    read_sleep_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h01 && sleep_active |=> rdata[4])
        else $error("sleep bit read low while not ready");
    sleep_hold_a: assert property (@(posedge clk) disable iff (srst)
        state.power == ciec_pkg::CIEC_ASLEEP &&
        !(access.wr && access.addr == 6'h01) |=> sleep_active)
        else $error("left sleep without write");
    restart_keep_a: assert property (@(posedge clk) disable iff (srst)
        access.wr && access.addr == 6'h01 && access.wdata[4] &&
        state.command[3:0] == 4'hF && !sleep_active |=> !state.command[4])
        else $error("sleep bit set during restart");

    // Read path
    read_cmd_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h01 |=> rdata[7:6] == 2'b00)
        else $error("command reserved bits read");
    read_sec_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h03 |=> rdata[6:5] == 2'b00)
        else $error("secondary reserved bits read");
    read_unmapped_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && (access.addr == 6'h00 || access.addr > 6'h03) |=>
        rdata == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (@(posedge clk) disable iff (srst)
        !access.rd |=> $stable(rdata))
        else $error("read data changed without read");
    rcv_read_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h01 |=>
        rdata[5] == $past(receiver_analog_off))
        else $error("receiver off read wrong");
    prim_read_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h02 |=>
        rdata == $past(state.primary))
        else $error("primary read wrong");
    sec_read_a: assert property (@(posedge clk) disable iff (srst)
        access.rd && access.addr == 6'h03 |=>
        rdata == $past(state.secondary))
        else $error("secondary read wrong");

    // Engine updates of the command field
    engine_load_a: assert property (@(posedge clk) disable iff (srst)
        engine_load && !access.wr |=>
        active_command == $past(engine_command))
        else $error("engine command not loaded");
    done_keep_a: assert property (@(posedge clk) disable iff (srst)
        engine_done && !engine_load && !access.wr |=>
        $stable(receiver_analog_off))
        else $error("done touched receiver bit");

    // Alert pin, independent of any write
    pin_summary_a: assert property (@(posedge clk) disable iff (srst)
        !summary_irq && state.primary[7] && !state.secondary[7] |->
        !alert_pin_oe)
        else $error("pin driven while it should float");
    prim_gate_a: assert property (@(posedge clk) disable iff (srst)
        state.primary[6:0] == 7'h00 && state.secondary[4:0] == 5'h00 |->
        !summary_irq)
        else $error("summary set with all enables off");
    pin_low_a: assert property (@(posedge clk) disable iff (srst)
        !state.secondary[7] && !alert_pin_out |-> alert_pin_oe)
        else $error("open drain did not pull low");
endmodule // ciec_control

// *** verification/ciec_engine_model.sv ***
// Model of the internal command engine driving load and done pulses
`timescale 1ns/1ps
module ciec_engine_model #(
    parameter int RUN = 4
) (
    input wire logic clk,
    input wire logic start,
    input wire logic [3:0] code,
    output logic engine_load,
    output logic [3:0] engine_command,
    output logic engine_done
);
    initial begin
        engine_load = 1'b0;
        engine_done = 1'b0;
        engine_command = 4'h0;
    end
    // Load, run for RUN cycles, then report done
    always @(posedge clk) begin
        if (start) begin
            engine_load <= 1'b1;
            engine_command <= code;
            @(posedge clk);
            engine_load <= 1'b0;
            // Code is meaningless once load drops; show a changed value
            engine_command <= ~code;
            repeat (RUN) @(posedge clk);
            engine_done <= 1'b1;
            @(posedge clk);
            engine_done <= 1'b0;
        end
    end
endmodule // ciec_engine_model

// *** verification/tb_top.sv ***
// Testbench for the command and alert enable block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    ciec_pkg::ciec_access_type access = '0;
    ciec_pkg::ciec_primary_flags_type pf = '0;
    ciec_pkg::ciec_secondary_flags_type sf = '0;
    logic eng_start = 1'b0;
    logic [3:0] eng_code = 4'h0;
    logic [7:0] rdata;
    logic eload, edone, rcv_off, sleep, sum, pin, oe;
    logic [3:0] ecmd, act;
    int err_total = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    ciec_control dut (.clk(clk), .srst(srst), .access(access),
        .rdata(rdata), .engine_load(eload), .engine_command(ecmd),
        .engine_done(edone), .primary_flags(pf), .secondary_flags(sf),
        .receiver_analog_off(rcv_off), .sleep_active(sleep),
        .active_command(act), .summary_irq(sum), .alert_pin_out(pin),
        .alert_pin_oe(oe));
    ciec_engine_model #(.RUN(4)) engine (.clk(clk), .start(eng_start),
        .code(eng_code), .engine_load(eload), .engine_command(ecmd),
        .engine_done(edone));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        access <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        access <= '0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        access <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        access <= '0;
        @(posedge clk);
        #1 chk(rdata, exp);
    endtask
    // Expected bits: summary, pin level, pin enable
    task automatic irq(input logic [7:0] p, input logic [7:0] s,
        input logic [11:0] f, input logic [2:0] e);
        wr(6'h02, p);
        wr(6'h03, s);
        @(posedge clk);
        pf <= f[11:5];
        sf <= f[4:0];
        @(posedge clk);
        #1 chk({5'h00, sum, pin, oe}, {5'h00, e});
    endtask
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1 chk({5'h00, sum, pin, oe}, 8'h02);
        chk({7'h00, rcv_off}, 8'h01);
        rd(6'h01, 8'h20);
        rd(6'h02, 8'h80);
        rd(6'h03, 8'h00);
        rd(6'h04, 8'h00);
        wr(6'h03, 8'hFF);
        rd(6'h03, 8'h9F);
        wr(6'h01, 8'hC5);
        rd(6'h01, 8'h05);
        chk({act, 3'h0, rcv_off}, 8'h50);
        wr(6'h01, 8'h20);
        #1 chk({7'h00, rcv_off}, 8'h01);
        wr(6'h01, 8'h10);
        #1 chk({7'h00, sleep}, 8'h01);
        rd(6'h01, 8'h10);
        wr(6'h01, 8'h00);
        rd(6'h01, 8'h10);
        repeat (20) @(posedge clk);
        rd(6'h01, 8'h00);
        chk({7'h00, sleep}, 8'h00);
        wr(6'h01, 8'h0F);
        wr(6'h01, 8'h1F);
        rd(6'h01, 8'h0F);
        @(posedge clk);
        eng_start <= 1'b1;
        eng_code <= 4'h3;
        @(posedge clk);
        eng_start <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({4'h0, act}, 8'h03);
        repeat (6) @(posedge clk);
        #1 chk({4'h0, act}, 8'h00);
        rd(6'h01, 8'h00);
        for (int i = 0; i < 7; i++) begin
            irq(8'h01 << i, 8'h00, ~(12'h020 << i), 3'b001);
            irq(8'h01 << i, 8'h00, 12'h020 << i, 3'b110);
        end
        for (int i = 0; i < 5; i++) begin
            irq(8'h00, 8'h01 << i, ~(12'h001 << i), 3'b001);
            irq(8'h00, 8'h01 << i, 12'h001 << i, 3'b110);
        end
        irq(8'hC0, 8'h80, 12'h800, 3'b101);
        irq(8'h80, 8'h00, 12'h000, 3'b010);
        irq(8'h80, 8'h80, 12'h000, 3'b011);
        irq(8'h00, 8'h80, 12'h000, 3'b001);
        // Second reset in mid-run restores the floating pin
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 chk({5'h00, sum, pin, oe}, 8'h02);
        rd(6'h02, 8'h80);
        rd(6'h03, 8'h00);
        give_verdict();
    end
endmodule // tb_top
